// ---- design/erc_pkg.sv ----
// Summary of operation
// R1 - record every detected error, raise fault interrupt
// R2 - syndrome travels with signaled error to consumer
// R3 - record holds status, address, counters, unit info
// R4 - uncorrected data error: record and interrupt now
// R5 - correctable data forwarded corrected to consumer
// R6 - count each corrected error against threshold
// R7 - corrected only if corrected, not propagated
// R8 - deferred if deferred and not propagated
// R9 - possible silent propagation forces uncorrected type
// R10 - uncorrected: unrecoverable or uncontainable subtype
// R11 - latent: detected, never consumed, not deferred
// R12 - signaled: consumed or possibly consumed
// R13 - latent only when certainly not consumed
// R14 - producer unrecoverable means node cannot continue
// R15 - restartable: halted, independent of corrupt data
// R16 - recoverable: resume only after software repair
// R17 - consumer unrecoverable means cannot resume
// R18 - producer subtypes off; consumer subtypes optional
// R19 - other error sources raise recovery or fault irq
// R20 - software fault raises recovery interrupt
// R21 - each new error updates type flags and subtype
// R22 - exactly one type; propagation checked first
package erc_pkg;
  localparam int DATA_W = 32;
  localparam int SYND_W = 16;
  localparam int ADDR_W = 32;
  localparam int UNIT_W = 8;
  localparam int CNT_W = 16;
  localparam int APB_AW = 12;
  // register byte offsets
  localparam logic [APB_AW-1:0] OFF_STATUS = 12'h000;
  localparam logic [APB_AW-1:0] OFF_ADDR = 12'h004;
  localparam logic [APB_AW-1:0] OFF_MISC = 12'h008;
  localparam logic [APB_AW-1:0] OFF_COUNT = 12'h00C;
  localparam logic [APB_AW-1:0] OFF_CTRL = 12'h010;
  localparam logic [APB_AW-1:0] OFF_CLEAR = 12'h014;
  // status field positions
  localparam int ST_VALID = 0;
  localparam int ST_CE = 1;
  localparam int ST_DE = 2;
  localparam int ST_UE = 3;
  localparam int ST_OF = 4;
  localparam int ST_ADDRV = 5;
  localparam int ST_SUB_LO = 8;
  localparam int ST_SYN_LO = 16;
  // control field positions
  localparam int CT_EN = 0;
  localparam int CT_FIE = 1;
  localparam int CT_ERIE = 2;
  localparam int CT_CSUB = 3;
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0007;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
  localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
  typedef enum logic [2:0] {
    SUB_NONE, SUB_UNRECOVERABLE, SUB_UNCONTAINABLE, SUB_RESTARTABLE, SUB_RECOVERABLE
  } erc_sub_t;
endpackage : erc_pkg

// ---- design/erc_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module erc_top (
  input wire logic CLK,
  input wire logic RSTN,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [erc_pkg::APB_AW-1:0] PADDR,
  input wire logic [erc_pkg::DATA_W-1:0] PWDATA,
  output logic [erc_pkg::DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // detection report, one-cycle valid
  input wire logic DET_VALID,
  input wire logic DET_CORRECTED,
  input wire logic DET_DEFERRED,
  input wire logic DET_MAYBE_PROPAGATED,
  input wire logic DET_CONSUMED,
  input wire logic DET_RELIES_ON_DATA,
  input wire logic DET_CAN_RESUME,
  input wire logic DET_ADDR_VALID,
  input wire logic [erc_pkg::ADDR_W-1:0] DET_ADDR,
  input wire logic [erc_pkg::SYND_W-1:0] DET_SYNDROME,
  input wire logic [erc_pkg::UNIT_W-1:0] DET_UNIT,
  input wire logic [erc_pkg::DATA_W-1:0] DET_DATA,
  input wire logic [erc_pkg::DATA_W-1:0] DET_FIX_MASK,
  input wire logic OTHER_ERR,
  input wire logic SW_FAULT,
  // consumer side
  output logic FWD_VALID,
  output logic [erc_pkg::DATA_W-1:0] FWD_DATA,
  output logic FWD_POISON,
  output logic [erc_pkg::SYND_W-1:0] FWD_SYNDROME,
  // interrupt controller side
  output logic FAULT_IRQ,
  output logic RECOVERY_IRQ
);
  // ==========================================================
  // state
  typedef struct packed {
    logic valid;
    logic ce;
    logic de;
    logic ue;
    logic ovf;
    logic addrv;
    erc_pkg::erc_sub_t sub;
    logic [erc_pkg::SYND_W-1:0] synd;
    logic [erc_pkg::ADDR_W-1:0] addr;
    logic [erc_pkg::UNIT_W-1:0] unit;
    logic [erc_pkg::CNT_W-1:0] cnt;
    logic [erc_pkg::DATA_W-1:0] ctrl;
    logic fault_irq;
    logic rec_irq;
    logic fwd_v;
    logic [erc_pkg::DATA_W-1:0] fwd_d;
    logic fwd_p;
    logic [erc_pkg::SYND_W-1:0] fwd_s;
    logic [erc_pkg::DATA_W-1:0] rdata;
  } erc_state_t;

  erc_state_t st_reg;
  erc_state_t st_next;
  logic wr_en;
  logic rd_en;
  logic is_ce;
  logic is_de;
  logic is_ue;
  erc_pkg::erc_sub_t sub_new;

  function automatic logic hit(input logic [erc_pkg::APB_AW-1:0] a, input logic [erc_pkg::APB_AW-1:0] o);
    hit = (a == o);
  endfunction : hit

  // ==========================================================
  // classification
  always_comb begin
    // R22 propagation first
    // R9 propagation forces uncorrected
    is_ue = DET_MAYBE_PROPAGATED || (!DET_CORRECTED && !DET_DEFERRED);
    // R7 corrected only when clean
    is_ce = !is_ue && DET_CORRECTED;
    // R8 deferred when clean
    is_de = !is_ue && !DET_CORRECTED;
    sub_new = erc_pkg::SUB_NONE;
    if (is_ue) begin
      // R10 containment subtype
      if (DET_MAYBE_PROPAGATED) begin
        sub_new = erc_pkg::SUB_UNCONTAINABLE;
      end else if (st_reg.ctrl[erc_pkg::CT_CSUB] && DET_CONSUMED) begin
        // R18 consumer subtypes only when enabled
        if (!DET_CAN_RESUME) begin
          // R17 cannot resume
          sub_new = erc_pkg::SUB_UNRECOVERABLE;
        end else if (DET_RELIES_ON_DATA) begin
          // R16 needs software repair
          sub_new = erc_pkg::SUB_RECOVERABLE;
        end else begin
          // R15 proceeds without repair
          sub_new = erc_pkg::SUB_RESTARTABLE;
        end
      end else begin
        // R11 R12 R13 R14 producer subtypes left out
        sub_new = erc_pkg::SUB_UNRECOVERABLE;
      end
    end
  end

  // ==========================================================
  // next state
  assign wr_en = PSEL && PENABLE && PWRITE;
  assign rd_en = PSEL && !PENABLE && !PWRITE;

  always_comb begin
    st_next = st_reg;
    st_next.fwd_v = 1'b0;
    // R19 other sources to recovery irq
    // R20 software fault to recovery irq
    st_next.rec_irq = st_reg.rec_irq || OTHER_ERR || SW_FAULT;
    st_next.fault_irq = st_reg.fault_irq || OTHER_ERR;
    if (wr_en) begin
      if (hit(PADDR, erc_pkg::OFF_CTRL)) begin
        st_next.ctrl = PWDATA;
      end
      if (hit(PADDR, erc_pkg::OFF_COUNT)) begin
        st_next.cnt = PWDATA[erc_pkg::CNT_W-1:0];
      end
      if (hit(PADDR, erc_pkg::OFF_CLEAR)) begin
        // write one to clear; a same-cycle event below wins
        if (PWDATA[erc_pkg::ST_VALID]) begin
          st_next.valid = 1'b0;
          st_next.ce = 1'b0;
          st_next.de = 1'b0;
          st_next.ue = 1'b0;
          st_next.addrv = 1'b0;
          st_next.sub = erc_pkg::SUB_NONE;
        end
        if (PWDATA[erc_pkg::ST_OF]) begin
          st_next.ovf = 1'b0;
        end
        if (PWDATA[erc_pkg::CT_FIE]) begin
          st_next.fault_irq = OTHER_ERR;
        end
        if (PWDATA[erc_pkg::CT_ERIE]) begin
          st_next.rec_irq = OTHER_ERR || SW_FAULT;
        end
      end
    end
    if (DET_VALID) begin
      st_next.fwd_v = 1'b1;
      // R5 correct and forward
      st_next.fwd_d = DET_DATA ^ (DET_CORRECTED && !is_ue ? DET_FIX_MASK : '0);
      st_next.fwd_p = !is_ce;
      // R2 syndrome sent with signaled error
      st_next.fwd_s = DET_SYNDROME;
      if (st_reg.ctrl[erc_pkg::CT_EN]) begin
        // R1 capture into record
        // R21 type flags follow new error
        st_next.valid = 1'b1;
        st_next.ce = is_ce;
        st_next.de = is_de;
        st_next.ue = is_ue;
        st_next.sub = sub_new;
        // R3 syndrome, address, unit
        st_next.synd = DET_SYNDROME;
        st_next.addrv = DET_ADDR_VALID;
        st_next.addr = DET_ADDR_VALID ? DET_ADDR : st_reg.addr;
        st_next.unit = DET_UNIT;
        if (is_ce) begin
          // R6 count each corrected error
          st_next.cnt = st_reg.cnt + erc_pkg::CNT_ONE;
          if (st_reg.cnt == erc_pkg::CNT_MAX) begin
            st_next.ovf = 1'b1;
          end
        end
        // R4 uncorrected raises fault irq
        if (st_reg.ctrl[erc_pkg::CT_FIE] && (is_ue || is_de || st_reg.cnt == erc_pkg::CNT_MAX)) begin
          st_next.fault_irq = 1'b1;
        end
        if (st_reg.ctrl[erc_pkg::CT_ERIE] && is_ue) begin
          st_next.rec_irq = 1'b1;
        end
      end
    end
    if (rd_en) begin
      st_next.rdata = '0;
      unique case (PADDR)
        erc_pkg::OFF_STATUS: begin
          st_next.rdata[erc_pkg::ST_VALID] = st_reg.valid;
          st_next.rdata[erc_pkg::ST_CE] = st_reg.ce;
          st_next.rdata[erc_pkg::ST_DE] = st_reg.de;
          st_next.rdata[erc_pkg::ST_UE] = st_reg.ue;
          st_next.rdata[erc_pkg::ST_OF] = st_reg.ovf;
          st_next.rdata[erc_pkg::ST_ADDRV] = st_reg.addrv;
          st_next.rdata[erc_pkg::ST_SUB_LO +: 3] = st_reg.sub;
          st_next.rdata[erc_pkg::ST_SYN_LO +: erc_pkg::SYND_W] = st_reg.synd;
        end
        erc_pkg::OFF_ADDR: st_next.rdata = st_reg.addr;
        erc_pkg::OFF_MISC: st_next.rdata[erc_pkg::UNIT_W-1:0] = st_reg.unit;
        erc_pkg::OFF_COUNT: st_next.rdata[erc_pkg::CNT_W-1:0] = st_reg.cnt;
        erc_pkg::OFF_CTRL: st_next.rdata = st_reg.ctrl;
        default: st_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      st_reg <= '0;
      st_reg.ctrl <= erc_pkg::CTRL_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================
  // outputs
  assign PRDATA = st_reg.rdata;
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !(hit(PADDR, erc_pkg::OFF_STATUS) || hit(PADDR, erc_pkg::OFF_ADDR) ||
    hit(PADDR, erc_pkg::OFF_MISC) || hit(PADDR, erc_pkg::OFF_COUNT) || hit(PADDR, erc_pkg::OFF_CTRL) ||
    (hit(PADDR, erc_pkg::OFF_CLEAR) && PWRITE));
  assign FWD_VALID = st_reg.fwd_v;
  assign FWD_DATA = st_reg.fwd_d;
  assign FWD_POISON = st_reg.fwd_p;
  assign FWD_SYNDROME = st_reg.fwd_s;
  assign FAULT_IRQ = st_reg.fault_irq;
  assign RECOVERY_IRQ = st_reg.rec_irq;
endmodule : erc_top
`default_nettype wire

// ---- dv/erc_sva.sv ----
`timescale 1ns/1ps
`default_nettype none
module erc_sva (
  input wire logic CLK,
  input wire logic RSTN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic DET_VALID,
  input wire logic DET_CORRECTED,
  input wire logic DET_DEFERRED,
  input wire logic DET_MAYBE_PROPAGATED,
  input wire logic OTHER_ERR,
  input wire logic SW_FAULT,
  input wire logic FWD_VALID,
  input wire logic FWD_POISON,
  input wire logic FAULT_IRQ,
  input wire logic RECOVERY_IRQ
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);
  sequence ue_s;
    DET_VALID && !DET_CORRECTED && !DET_DEFERRED;
  endsequence
  fwd_pulse_a: assert property (DET_VALID |=> FWD_VALID) else $error("no forward");
  fwd_idle_a: assert property (!DET_VALID |=> !FWD_VALID) else $error("stray forward");
  ce_clean_a: assert property (DET_VALID && DET_CORRECTED && !DET_MAYBE_PROPAGATED |=> !FWD_POISON)
    else $error("corrected poisoned");
  prop_ue_a: assert property (DET_VALID && DET_MAYBE_PROPAGATED |=> FWD_POISON) else $error("prop clean");
  de_poison_a: assert property (DET_VALID && DET_DEFERRED && !DET_CORRECTED |=> FWD_POISON)
    else $error("deferred clean");
  ue_irq_a: assert property (ue_s |=> FAULT_IRQ) else $error("no fault irq");
  sw_irq_a: assert property (SW_FAULT |=> RECOVERY_IRQ) else $error("no recovery irq");
  other_irq_a: assert property (OTHER_ERR |=> FAULT_IRQ && RECOVERY_IRQ) else $error("other lost");
  irq_hold_a: assert property (FAULT_IRQ && !PSEL |=> FAULT_IRQ) else $error("irq dropped");
  apb_ready_a: assert property (PSEL && PENABLE |-> PREADY) else $error("not ready");
endmodule : erc_sva
bind erc_top erc_sva u_sva (.*);
`default_nettype wire

// ---- dv/erc_consumer.sv ----
`timescale 1ns/1ps
`default_nettype none
module erc_consumer (
  input wire logic clk,
  input wire logic fwd_valid,
  input wire logic fwd_poison,
  input wire logic [erc_pkg::SYND_W-1:0] fwd_syndrome,
  output logic [7:0] n_poison,
  output logic [erc_pkg::SYND_W-1:0] last_syn
);
  initial n_poison = 8'h00;
  always @(posedge clk) begin
    if (fwd_valid) begin
      last_syn <= fwd_syndrome;
      n_poison <= n_poison + 8'(fwd_poison);
    end
  end
endmodule : erc_consumer
`default_nettype wire

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic CLK = 0, RSTN = 0, PSEL = 0, PENABLE = 0, PWRITE = 0, DET_VALID = 0, DET_CORRECTED = 0;
  logic DET_DEFERRED = 0, DET_MAYBE_PROPAGATED = 0, DET_CONSUMED = 0, DET_RELIES_ON_DATA = 0;
  logic DET_CAN_RESUME = 0, DET_ADDR_VALID = 0, OTHER_ERR = 0, SW_FAULT = 0, er;
  logic [11:0] PADDR = '0;
  logic [31:0] PWDATA = '0, DET_DATA = 32'h1234_5678, DET_FIX_MASK = 32'h0000_00FF, DET_ADDR = '0;
  logic [15:0] DET_SYNDROME = '0, FWD_SYNDROME, last_syn;
  logic [7:0] DET_UNIT = '0, n_poison;
  logic [31:0] PRDATA, FWD_DATA, rd;
  logic PREADY, PSLVERR, FWD_VALID, FWD_POISON, FAULT_IRQ, RECOVERY_IRQ;
  int n_errors = 0, compares = 0, cyc = 0;
  // row: corrected deferred propagated consumed relies resume | type ue de ce | subtype
  logic [11:0] rows [8] = '{12'h808, 12'h410, 12'h622, 12'h021, 12'h1E4, 12'h163, 12'h121, 12'hA22};
  erc_top uut (.*);
  erc_consumer u_cons (.clk(CLK), .fwd_valid(FWD_VALID), .fwd_poison(FWD_POISON),
    .fwd_syndrome(FWD_SYNDROME), .n_poison(n_poison), .last_syn(last_syn));
  initial forever #5 CLK = ~CLK;
  task automatic tally_and_finish;
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    // start on a rising edge so the request never moves between edges
    @(posedge CLK);
    PSEL <= '1; PWRITE <= w; PADDR <= a; PWDATA <= d;
    @(posedge CLK) PENABLE <= '1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rd = PRDATA; er = PSLVERR;
    PSEL <= '0; PENABLE <= '0;
    @(posedge CLK);
  endtask : apb
  task automatic det(input logic [11:0] r, input logic [15:0] s);
    {DET_CORRECTED, DET_DEFERRED, DET_MAYBE_PROPAGATED, DET_CONSUMED, DET_RELIES_ON_DATA, DET_CAN_RESUME} <= r[11:6];
    DET_VALID <= '1; DET_SYNDROME <= s; DET_UNIT <= s[7:0];
    @(posedge CLK) DET_VALID <= '0;
    #1;
  endtask : det
  // long hang ends the run as a failure
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      tally_and_finish;
    end
  end
  initial begin
    repeat (3) @(posedge CLK);
    RSTN <= '1;
    @(posedge CLK);
    apb('0, erc_pkg::OFF_CTRL, '0);
    chk(rd, erc_pkg::CTRL_RST);
    apb('1, erc_pkg::OFF_CTRL, 32'h0000_000F);
    foreach (rows[i]) begin
      det(rows[i], 16'(i + 1));
      chk({FWD_VALID, FWD_POISON, FWD_SYNDROME}, {1'b1, rows[i][5:3] != 3'b001, 16'(i + 1)});
      chk(FWD_DATA, rows[i][5:3] == 3'b001 ? 32'h1234_5687 : DET_DATA);
      apb('0, erc_pkg::OFF_STATUS, '0);
      chk({rd[31:16], rd[10:8], rd[3:0]}, {16'(i + 1), rows[i][2:0], rows[i][5:3], 1'b1});
      $display("row %0d done", i);
    end
    chk({n_poison, last_syn}, 32'h0007_0008);
    apb('0, erc_pkg::OFF_MISC, '0);
    chk(rd[7:0], 8'h08);
    apb('0, erc_pkg::OFF_COUNT, '0);
    chk(rd, 32'h0000_0001);
    apb('1, erc_pkg::OFF_COUNT, 32'h0000_FFFF);
    det(12'h808, 16'h00AA);
    apb('0, erc_pkg::OFF_STATUS, '0);
    chk({rd[4], FAULT_IRQ}, 2'b11);
    apb('1, erc_pkg::OFF_CLEAR, 32'h0000_0017);
    apb('0, erc_pkg::OFF_STATUS, '0);
    chk({rd[4:0], FAULT_IRQ, RECOVERY_IRQ}, '0);
    SW_FAULT <= '1;
    @(posedge CLK) SW_FAULT <= '0;
    #1 chk({FAULT_IRQ, RECOVERY_IRQ}, 2'b01);
    @(posedge CLK) OTHER_ERR <= '1;
    @(posedge CLK) OTHER_ERR <= '0;
    #1 chk({FAULT_IRQ, RECOVERY_IRQ}, 2'b11);
    apb('0, 12'h0FC, '0);
    chk({er, rd[30:0]}, 32'h8000_0000);
    apb('0, erc_pkg::OFF_CLEAR, '0);
    chk(er, 1'b1);
    $display("side cases done");
    RSTN <= '0;
    @(posedge CLK) RSTN <= '1;
    @(posedge CLK);
    apb('0, erc_pkg::OFF_CTRL, '0);
    chk({rd, FAULT_IRQ}, {erc_pkg::CTRL_RST, 1'b0});
    $display("reset done");
    tally_and_finish;
  end
endmodule : tb_top
`default_nettype wire
